// *** hw/rbn_map.vh ***
// register map, field positions, codes and timing counts
`ifndef RBN_MAP_VH
`define RBN_MAP_VH
`define RBN_CLK_HZ 10000000
`define RBN_REFRESH_US 2000
`define RBN_REFRESH_CYCLES (`RBN_REFRESH_US * (`RBN_CLK_HZ / 1000000))
`define RBN_SAVE_MS 400
`define RBN_SAVE_CYCLES (`RBN_SAVE_MS * (`RBN_CLK_HZ / 1000))
`define RBN_ADDR_SPEED_CTL 5'h16
`define RBN_ADDR_SAVE 5'h18
`define RBN_ADDR_PH_ADV 5'h1a
`define RBN_ADDR_MOTOR 5'h1b
`define RBN_ADDR_RB_SEL 5'h1d
`define RBN_ADDR_DEMAND 5'h1e
`define RBN_ADDR_READBACK 5'h1f
`define RBN_NVM_WORDS 31
`define RBN_SLEEP_BIT 7
`define RBN_PAM_BIT 8
`define RBN_NOCLR_BIT 5
`define RBN_SAV_NONE 2'h0
`define RBN_SAV_ARMED 2'h1
`define RBN_SAV_GO 2'h2
`define RBN_ST_POR 14
`define RBN_ST_SE 13
`define RBN_ST_VPU 4
`define RBN_RB_DIAG 3'h0
`define RBN_RB_SPEED 3'h1
`define RBN_RB_CURRENT 3'h2
`define RBN_RB_VOLTAGE 3'h3
`define RBN_RB_TEMP 3'h4
`define RBN_RB_DEMAND 3'h5
`define RBN_RB_DUTY 3'h6
`define RBN_RB_PHASE 3'h7
`define RBN_PA_MANUAL_MAX 10'h03f
`define RBN_FRAME_BITS 5'h10
`define RBN_ADDR_LAST_RISE 5'h04
`define RBN_PREFIX_LAST_RISE 5'h03
`define RBN_WR_LAST_RISE 5'h05
`define RBN_SYNC_RESET 4'h6
`endif

// *** hw/rbn_sync.v ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module rbn_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VAL = 0
) (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= RESET_VAL;
            q_o <= RESET_VAL;
        end else if (ce_i) begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // rbn_sync
`default_nettype wire

// *** hw/rbn_nvm_store.v ***
// nonvolatile store: power-up load, word programming and verify
`timescale 1ns/100ps
`default_nettype none
`include "rbn_map.vh"
module rbn_nvm_store #(
    parameter WORDS = `RBN_NVM_WORDS,
    parameter SAVE_CYCLES = `RBN_SAVE_CYCLES
) (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire start_i,
    input wire vpp_low_i,
    input wire [8:0] image_i,
    output reg [4:0] index_o,
    output reg load_valid_o,
    output reg [4:0] load_index_o,
    output reg [8:0] load_data_o,
    output reg busy_o,
    output reg done_o,
    output reg fail_o,
    output reg vpp_abort_o
);
    localparam WORD_CYCLES = SAVE_CYCLES / WORDS;
    localparam [31:0] LAST_W = WORDS - 1;
    localparam [4:0] LAST = LAST_W[4:0];
    localparam S_LOAD = 2'h0;
    localparam S_IDLE = 2'h1;
    localparam S_PROG = 2'h2;
    localparam S_VERIFY = 2'h3;
    reg [8:0] cells [0:WORDS-1];
    reg [1:0] state;
    reg [31:0] wait_cnt;
    integer k;
    wire last = index_o == LAST;
    wire prog_tick = wait_cnt == WORD_CYCLES - 1;

    // erased array at first power up
    initial begin
        for (k = 0; k < WORDS; k = k + 1) begin
            cells[k] = 9'h000;
        end
    end

    // one word programmed per slot of the save time
    always @(posedge ref_clk_i) begin
        if (ce_i && state == S_PROG && prog_tick && !vpp_low_i) begin
            cells[index_o] <= image_i;
        end
    end

    // load walk, then idle, program, verify
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= S_LOAD;
            index_o <= 5'h00;
            wait_cnt <= 32'h0;
            load_valid_o <= 1'b0;
            load_index_o <= 5'h00;
            load_data_o <= 9'h000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            vpp_abort_o <= 1'b0;
        end else if (ce_i) begin
            load_valid_o <= 1'b0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            vpp_abort_o <= 1'b0;
            case (state)
            S_LOAD: begin
                load_valid_o <= 1'b1;
                load_index_o <= index_o;
                load_data_o <= cells[index_o];
                index_o <= last ? 5'h00 : index_o + 5'h01;
                if (last) begin
                    state <= S_IDLE;
                end
            end
            S_IDLE: begin
                if (start_i) begin
                    busy_o <= 1'b1;
                    index_o <= 5'h00;
                    wait_cnt <= 32'h0;
                    state <= S_PROG;
                end
            end
            S_PROG: begin
                if (vpp_low_i) begin
                    vpp_abort_o <= 1'b1;
                    busy_o <= 1'b0;
                    state <= S_IDLE;
                end else if (prog_tick) begin
                    wait_cnt <= 32'h0;
                    index_o <= last ? 5'h00 : index_o + 5'h01;
                    if (last) begin
                        state <= S_VERIFY;
                    end
                end else begin
                    wait_cnt <= wait_cnt + 32'h1;
                end
            end
            S_VERIFY: begin
                if (vpp_low_i) begin
                    vpp_abort_o <= 1'b1;
                    busy_o <= 1'b0;
                    state <= S_IDLE;
                end else if (cells[index_o] != image_i) begin
                    fail_o <= 1'b1;
                    busy_o <= 1'b0;
                    state <= S_IDLE;
                end else if (last) begin
                    done_o <= 1'b1;
                    busy_o <= 1'b0;
                    state <= S_IDLE;
                end else begin
                    index_o <= index_o + 5'h01;
                end
            end
            default: begin
                state <= S_IDLE;
            end
            endcase
        end
    end
endmodule // rbn_nvm_store
`default_nettype wire

// *** hw/rbn_top.v ***
// readback multiplexer, serial register port and nvm save control
`timescale 1ns/100ps
`default_nettype none
`include "rbn_map.vh"
// Summary of operation
// - readback select picks diag, speed, current, volts, temp, demand, duty, phase
// - readback frame: five status msbs, ten value bits, parity
// - speed readback is in speed resolution units like the demand
// - speed stays valid during forward windmilling
// - overspeed range bit extends speed by 1024 units
// - supply voltage code is 0.0528 V per count
// - temperature code falls as junction temperature rises
// - current, voltage and temperature refresh every 2 ms
// - demand readback returns the live demand field
// - duty readback full scale 1023 means full duty
// - manual phase advance codes 0..62 step 0.7, 63 is 60
// - auto phase advance is 0.7 degrees per count throughout
// - duty and phase advance refresh once per pwm period
// - save starts only on a 01 to 10 write of save field
// - save covers regs 0-23, 25-29 without sleep bit, demand 9:2
// - save takes about 400 ms and ends with a verify
// - writes during a save set fault summary and serial error
// - success sets save field to 01, abort clears it to 00
// - programming undervoltage aborts, flags it, clears save field
// - after power-on the nvm contents load into the registers
// - reads clear latched flags unless no-clear-on-read is set
// - diag bit 9 carries overspeed range bit, never sets status
module rbn_top #(
    parameter REFRESH_CYCLES = `RBN_REFRESH_CYCLES,
    parameter SAVE_CYCLES = `RBN_SAVE_CYCLES
) (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire strobe_n_i,
    input wire sck_i,
    input wire sdi_i,
    output reg sdo_o,
    output reg sdo_oe_n_o,
    input wire vpp_low_i,
    input wire [10:0] speed_count_i,
    input wire speed_driven_i,
    input wire windmill_fwd_i,
    input wire [9:0] supply_current_i,
    input wire [9:0] supply_voltage_i,
    input wire [9:0] chip_temp_i,
    input wire pwm_period_i,
    input wire [9:0] applied_duty_i,
    input wire [9:0] applied_phase_i,
    input wire demand_pwm_load_i,
    input wire [9:0] demand_pwm_i,
    input wire [12:0] status_fault_i,
    input wire [8:0] diag_fault_i,
    output reg [9:0] demand_input_field_o,
    output reg [2:0] speed_resolution_select_o,
    output reg phase_advance_auto_select_o,
    output reg save_busy_o,
    output reg fault_summary_flag_o
);
    wire [3:0] pin_s;
    reg sck_q, stb_q;
    reg [4:0] rise_cnt, fall_idx;
    reg [15:0] rx, out_word;
    reg [8:0] cfg [0:31];
    reg [14:0] st_flags, next_st_set;
    reg [8:0] diag_flags, image;
    reg [10:0] speed_q;
    reg [9:0] demand, cur_q, volt_q, temp_q, duty_q, phase_q, rb_value;
    reg [31:0] ref_cnt;
    wire nvm_busy, nvm_done, nvm_fail, nvm_vpp, load_valid;
    wire [4:0] nvm_index, load_index;
    wire [8:0] load_data;
    integer i;

    // odd parity over the first fifteen bits of a frame
    function par15;
        input [14:0] bits;
        begin
            par15 = ~^bits;
        end
    endfunction

    // pins cross into the clock domain
    rbn_sync #(
        .WIDTH(4),
        .RESET_VAL(`RBN_SYNC_RESET)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .d_i({vpp_low_i, strobe_n_i, sck_i, sdi_i}),
        .q_o(pin_s)
    );

    // edges of the synchronised strobe and clock
    wire sdi_s = pin_s[0];
    wire sck_rise = pin_s[1] & ~sck_q;
    wire sck_fall = ~pin_s[1] & sck_q;
    wire frame_start = stb_q & ~pin_s[2];
    wire frame_end = ~stb_q & pin_s[2];
    wire vpp_low_s = pin_s[3];

    // status word and control fields
    wire fault_summary = |st_flags;
    wire [15:0] status_word = {fault_summary, st_flags};
    wire [2:0] rb_sel = cfg[`RBN_ADDR_RB_SEL][2:0];
    wire no_clear = cfg[`RBN_ADDR_RB_SEL][`RBN_NOCLR_BIT];
    wire pa_auto = cfg[`RBN_ADDR_PH_ADV][`RBN_PAM_BIT];
    wire [1:0] sav_field = cfg[`RBN_ADDR_SAVE][1:0];
    wire [4:0] addr_now = {rx[3:0], sdi_s};

    // decode of a finished frame
    wire frame_ok = (rise_cnt == `RBN_FRAME_BITS) & (^rx);
    wire [4:0] rx_addr = rx[15:11];
    wire rx_wr = rx[10];
    wire is_rb = rx_addr == `RBN_ADDR_READBACK;
    wire is_dem = rx_addr == `RBN_ADDR_DEMAND;
    wire wr_req = frame_end & frame_ok & ~is_rb & (is_dem | rx_wr);
    wire rd_req = frame_end & frame_ok & ~is_dem & (is_rb | ~rx_wr);
    wire bad_frame = frame_end & ~frame_ok & (rise_cnt != 5'h00);
    wire wr_blocked = wr_req & nvm_busy;
    wire wr_do = wr_req & ~nvm_busy;
    wire rd_clear = rd_req & ~no_clear;
    // save only on a 01 to 10 write
    wire sav_start = wr_do & (rx_addr == `RBN_ADDR_SAVE)
        & (sav_field == `RBN_SAV_ARMED) & (rx[2:1] == `RBN_SAV_GO);

    always @* begin
        case (rb_sel)
        `RBN_RB_DIAG: rb_value = {speed_q[10], diag_flags};
        `RBN_RB_SPEED: rb_value = speed_q[9:0];
        `RBN_RB_CURRENT: rb_value = cur_q;
        `RBN_RB_VOLTAGE: rb_value = volt_q;
        `RBN_RB_TEMP: rb_value = temp_q;
        `RBN_RB_DEMAND: rb_value = demand;
        `RBN_RB_DUTY: rb_value = duty_q;
        `RBN_RB_PHASE: rb_value = phase_q;
        default: rb_value = 10'h000;
        endcase
    end

    always @* begin
        if (nvm_index == `RBN_ADDR_DEMAND) begin
            image = {1'b0, demand[9:2]};
        end else if (nvm_index == `RBN_ADDR_SAVE) begin
            image = 9'h000;
        end else if (nvm_index == `RBN_ADDR_MOTOR) begin
            image = cfg[nvm_index] & ~(9'h001 << `RBN_SLEEP_BIT);
        end else begin
            image = cfg[nvm_index];
        end
    end

    rbn_nvm_store #(
        .WORDS(`RBN_NVM_WORDS),
        .SAVE_CYCLES(SAVE_CYCLES)
    ) u_nvm (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .start_i(sav_start),
        .vpp_low_i(vpp_low_s),
        .image_i(image),
        .index_o(nvm_index),
        .load_valid_o(load_valid),
        .load_index_o(load_index),
        .load_data_o(load_data),
        .busy_o(nvm_busy),
        .done_o(nvm_done),
        .fail_o(nvm_fail),
        .vpp_abort_o(nvm_vpp)
    );

    // serial shift engine, data out on falling clock
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sck_q <= 1'b1;
            stb_q <= 1'b1;
            rise_cnt <= 5'h00;
            fall_idx <= 5'h00;
            rx <= 16'h0000;
            out_word <= 16'h0000;
            sdo_o <= 1'b0;
            sdo_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            sck_q <= pin_s[1];
            stb_q <= pin_s[2];
            if (frame_start) begin
                rise_cnt <= 5'h00;
                fall_idx <= 5'h00;
                out_word <= {status_word[15:11], 11'h000};
                sdo_o <= status_word[15];
                sdo_oe_n_o <= 1'b0;
            end else if (frame_end) begin
                sdo_o <= 1'b0;
                sdo_oe_n_o <= 1'b1;
            end else if (!pin_s[2]) begin
                if (sck_rise) begin
                    rx <= {rx[14:0], sdi_s};
                    if (rise_cnt != 5'h1f) begin
                        rise_cnt <= rise_cnt + 5'h01;
                    end
                    // top value bit leaves before the address ends
                    if (rise_cnt == `RBN_PREFIX_LAST_RISE
                        && {rx[2:0], sdi_s, 1'b1} == `RBN_ADDR_READBACK) begin
                        out_word[10] <= rb_value[9];
                    end
                    if (rise_cnt == `RBN_ADDR_LAST_RISE) begin
                        if (addr_now == `RBN_ADDR_READBACK) begin
                            out_word[9:0] <= {rb_value[8:0], par15({
                                out_word[15:10], rb_value[8:0]})};
                        end else begin
                            out_word[10:0] <= {1'b0, cfg[addr_now],
                                par15({out_word[15:11], 1'b0, cfg[addr_now]})};
                        end
                    end
                    if (rise_cnt == `RBN_WR_LAST_RISE && sdi_s
                        && rx[4:0] != `RBN_ADDR_READBACK) begin
                        out_word[9:0] <= {status_word[8:0],
                            par15({out_word[15:11], 1'b0, status_word[8:0]})};
                    end
                end
                if (sck_fall && fall_idx != 5'h1f) begin
                    fall_idx <= fall_idx + 5'h01;
                    sdo_o <= (fall_idx < 5'h0f) ?
                        out_word[4'he - fall_idx[3:0]] : 1'b0;
                end
            end
        end
    end

    // configuration registers: load, serial write, save result
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (i = 0; i < 32; i = i + 1) begin
                cfg[i] <= 9'h000;
            end
        end else if (ce_i) begin
            if (load_valid && load_index < `RBN_ADDR_DEMAND
                && load_index != `RBN_ADDR_SAVE) begin
                cfg[load_index] <= load_data;
            end
            if (wr_do && !is_dem) begin
                cfg[rx_addr] <= rx[9:1];
            end
            if (nvm_done) begin
                cfg[`RBN_ADDR_SAVE][1:0] <= `RBN_SAV_ARMED;
            end
            if (nvm_fail || nvm_vpp) begin
                cfg[`RBN_ADDR_SAVE][1:0] <= `RBN_SAV_NONE;
            end
        end
    end

    // demand field from serial, pwm input or nvm
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            demand <= 10'h000;
        end else if (ce_i) begin
            if (load_valid && load_index == `RBN_ADDR_DEMAND) begin
                demand <= {load_data[7:0], 2'h0};
            end else if (wr_do && is_dem) begin
                demand <= rx[10:1];
            end else if (demand_pwm_load_i) begin
                demand <= demand_pwm_i;
            end
        end
    end

    // status events: set wins over a read clear
    always @* begin
        next_st_set = {2'h0, status_fault_i};
        next_st_set[`RBN_ST_SE] = bad_frame | wr_blocked;
        next_st_set[`RBN_ST_VPU] = status_fault_i[`RBN_ST_VPU] | nvm_vpp;
    end

    // latched status and diagnostic flags
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_flags <= 15'h4000;
            diag_flags <= 9'h000;
        end else if (ce_i) begin
            st_flags <= (rd_clear ? 15'h0000 : st_flags) | next_st_set;
            if (rd_clear && is_rb && rb_sel == `RBN_RB_DIAG) begin
                diag_flags <= diag_fault_i;
            end else begin
                diag_flags <= diag_flags | diag_fault_i;
            end
        end
    end

    // measurement capture
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            speed_q <= 11'h000;
            cur_q <= 10'h000;
            volt_q <= 10'h000;
            temp_q <= 10'h000;
            duty_q <= 10'h000;
            phase_q <= 10'h000;
            ref_cnt <= 32'h0;
        end else if (ce_i) begin
            // units, windmill valid, range bit 10
            speed_q <= (speed_driven_i | windmill_fwd_i) ?
                speed_count_i : 11'h000;
            // slow measurements on a 2 ms tick
            if (ref_cnt == REFRESH_CYCLES - 1) begin
                ref_cnt <= 32'h0;
                cur_q <= supply_current_i;
                // bridge supply code passed as is
                volt_q <= supply_voltage_i;
                temp_q <= chip_temp_i;
            end else begin
                ref_cnt <= ref_cnt + 32'h1;
            end
            // duty and advance per pwm period
            if (pwm_period_i) begin
                duty_q <= applied_duty_i;
                // manual mode tops out at 63
                if (!pa_auto && applied_phase_i > `RBN_PA_MANUAL_MAX) begin
                    phase_q <= `RBN_PA_MANUAL_MAX;
                end else begin
                    phase_q <= applied_phase_i;
                end
            end
        end
    end

    // registered copies of fields for the rest of the chip
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            demand_input_field_o <= 10'h000;
            speed_resolution_select_o <= 3'h0;
            phase_advance_auto_select_o <= 1'b0;
            save_busy_o <= 1'b0;
            fault_summary_flag_o <= 1'b0;
        end else if (ce_i) begin
            demand_input_field_o <= demand;
            speed_resolution_select_o <= cfg[`RBN_ADDR_SPEED_CTL][2:0];
            phase_advance_auto_select_o <= pa_auto;
            save_busy_o <= nvm_busy;
            fault_summary_flag_o <= fault_summary;
        end
    end
endmodule // rbn_top
`default_nettype wire

// *** sim/rbn_top_properties.sv ***
// port assertions for the serial output enable, demand field, fault summary and save sequencer
`timescale 1ns/100ps
`default_nettype none
module rbn_top_properties #(
    parameter int SAVE_CYCLES = 310
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic strobe_n_i,
    input wire logic vpp_low_i,
    input wire logic demand_pwm_load_i,
    input wire logic [9:0] demand_pwm_i,
    input wire logic [12:0] status_fault_i,
    input wire logic sdo_oe_n_o,
    input wire logic [9:0] demand_input_field_o,
    input wire logic [2:0] speed_resolution_select_o,
    input wire logic save_busy_o,
    input wire logic fault_summary_flag_o
);
    int busy_cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // cycles spent in the current save
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            busy_cnt <= 0;
        else
            busy_cnt <= save_busy_o ? busy_cnt + 1 : 0;
    end
    chk_oe_idle: assert property (strobe_n_i [*5] |-> sdo_oe_n_o)
        else $error("sdo enabled outside a frame");
    chk_oe_drive: assert property (!strobe_n_i [*5] |-> !sdo_oe_n_o)
        else $error("sdo not driven inside a frame");
    chk_demand_load: assert property (demand_pwm_load_i |-> ##2
        demand_input_field_o == $past(demand_pwm_i, 2))
        else $error("demand field missed a pwm load");
    chk_fault_set: assert property (status_fault_i != 13'h0000
        |-> ##[1:3] fault_summary_flag_o)
        else $error("fault summary not raised");
    chk_vpp_abort: assert property (save_busy_o && vpp_low_i
        |-> ##[1:8] !save_busy_o && fault_summary_flag_o)
        else $error("save not stopped on low programming voltage");
    chk_save_bound: assert property (busy_cnt < SAVE_CYCLES + 80)
        else $error("save runs too long");
    chk_save_start: assert property ($rose(save_busy_o)
        |-> $past(strobe_n_i, 3))
        else $error("save started inside a frame");
    chk_busy_locked: assert property (save_busy_o && $past(save_busy_o)
        |-> $stable(speed_resolution_select_o))
        else $error("register changed during a save");
    cover property ($rose(save_busy_o));
    cover property ($fell(save_busy_o) && fault_summary_flag_o);
    cover property ($fell(sdo_oe_n_o));
endmodule // rbn_top_properties
bind rbn_top rbn_top_properties #(.SAVE_CYCLES(SAVE_CYCLES)) i_props (
    .ref_clk_i, .reset_n_i, .strobe_n_i, .vpp_low_i, .demand_pwm_load_i,
    .demand_pwm_i, .status_fault_i, .sdo_oe_n_o, .demand_input_field_o,
    .speed_resolution_select_o, .save_busy_o, .fault_summary_flag_o);
`default_nettype wire

// *** sim/rbn_host.sv ***
// serial master model that runs one frame per call
`timescale 1ns/100ps
`default_nettype none
module rbn_host (
    input wire logic ref_clk_i,
    input wire logic sdo_i,
    output logic strobe_n_o = 1'b1,
    output logic sck_o = 1'b1,
    output logic sdi_o = 1'b0
);
    // n bits msb first, reply bit taken before each falling sck
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        @(negedge ref_clk_i) strobe_n_o = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        for (int i = 0; i < n; i++) begin
            r[15 - i] = sdo_i;
            sck_o = 1'b0;
            sdi_o = w[15 - i];
            repeat (4) @(negedge ref_clk_i);
            sck_o = 1'b1;
            repeat (4) @(negedge ref_clk_i);
        end
        strobe_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line shows no stale bit
        repeat (10) @(negedge ref_clk_i);
    endtask
endmodule // rbn_host
`default_nettype wire

// *** sim/rbn_top_test.sv ***
// self-checking bench for the readback mux and save sequencer
`timescale 1ns/100ps
`default_nettype none
module rbn_top_test;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, vpp_low_i = 1'b0;
    logic strobe_n_i, sck_i, sdi_i, sdo_o, sdo_oe_n_o, save_busy_o;
    logic speed_driven_i = 1'b1, windmill_fwd_i = 1'b0, pwm_period_i = 1'b0;
    logic demand_pwm_load_i = 1'b0, phase_advance_auto_select_o;
    logic fault_summary_flag_o;
    logic [10:0] speed_count_i = 11'h4a5;
    logic [9:0] supply_current_i = 10'h123, supply_voltage_i = 10'h2b7;
    logic [9:0] chip_temp_i = 10'h1c4, applied_duty_i = 10'h3ff;
    logic [9:0] applied_phase_i = 10'h015, demand_pwm_i = 10'h0cb;
    logic [9:0] demand_input_field_o;
    logic [12:0] status_fault_i = 13'h0000;
    logic [8:0] diag_fault_i = 9'h000;
    logic [2:0] speed_resolution_select_o;
    logic [15:0] rsp;
    logic [9:0] exp_rb [8] = '{10'h200, 10'h0a5, 10'h123, 10'h2b7, 10'h1c4,
                               10'h3a5, 10'h3ff, 10'h015};
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    rbn_top #(.REFRESH_CYCLES(20), .SAVE_CYCLES(310)) i_dut (
        .ref_clk_i, .reset_n_i, .ce_i, .strobe_n_i, .sck_i, .sdi_i, .sdo_o,
        .sdo_oe_n_o, .vpp_low_i, .speed_count_i, .speed_driven_i,
        .windmill_fwd_i, .supply_current_i, .supply_voltage_i, .chip_temp_i,
        .pwm_period_i, .applied_duty_i, .applied_phase_i, .demand_pwm_load_i,
        .demand_pwm_i, .status_fault_i, .diag_fault_i, .demand_input_field_o,
        .speed_resolution_select_o, .phase_advance_auto_select_o,
        .save_busy_o, .fault_summary_flag_o);
    rbn_host i_host (.ref_clk_i, .sdo_i(sdo_o), .strobe_n_o(strobe_n_i),
        .sck_o(sck_i), .sdi_o(sdi_i));
    // 10 mhz reference clock
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // pwm period pulse every 16 cycles and hang guard
    always @(negedge ref_clk_i) begin
        cycles <= cycles + 1;
        pwm_period_i <= (cycles % 16) == 0;
        if (cycles == 20000) begin
            fail_count++;
            test_done;
        end
    end
    function automatic logic [15:0] fr(input logic [4:0] a, input logic w,
                                       input logic [8:0] d);
        fr = {a, w, d, ~^{a, w, d}};
    endfunction
    function automatic logic [15:0] rs(input logic [4:0] s,
                                       input logic [9:0] v);
        rs = {s, v, ~^{s, v}};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [8:0] d);
        i_host.xfer(fr(a, 1'b1, d), 16, rsp);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        i_host.xfer(fr(a, 1'b0, 9'h000), 16, rsp);
        check(rsp, exp);
    endtask
    task automatic rb(input logic [2:0] s, input logic [9:0] v);
        wr(5'h1d, {6'h00, s});
        rd(5'h1f, rs(5'h00, v));
    endtask
    task automatic reset_dut;
        reset_n_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (45) @(negedge ref_clk_i);
    endtask
    task automatic save;
        wr(5'h18, 9'h001);
        wr(5'h18, 9'h002);
        check({15'h0000, save_busy_o}, 16'h0001);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        reset_dut;
        rd(5'h16, rs(5'h18, 10'h000));
        rd(5'h16, rs(5'h00, 10'h000));
        $display("power-on test done");
        wr(5'h1e, 9'h1a5);
        for (int i = 0; i < 8; i++) rb(3'(i), exp_rb[i]);
        speed_driven_i = 1'b0;
        windmill_fwd_i = 1'b1;
        rb(3'h1, 10'h0a5);
        windmill_fwd_i = 1'b0;
        applied_phase_i = 10'h05a;
        rb(3'h7, 10'h03f);
        wr(5'h1a, 9'h100);
        rb(3'h7, 10'h05a);
        check({15'h0000, phase_advance_auto_select_o}, 16'h0001);
        demand_pwm_load_i = 1'b1;
        @(negedge ref_clk_i) demand_pwm_load_i = 1'b0;
        rb(3'h5, 10'h0cb);
        $display("readback test done");
        wr(5'h16, 9'h005);
        status_fault_i = 13'h0008;
        diag_fault_i = 9'h011;
        @(negedge ref_clk_i) status_fault_i = 13'h0000;
        diag_fault_i = 9'h000;
        i_host.xfer(fr(5'h16, 1'b1, 9'h002) ^ 16'h0001, 16, rsp);
        i_host.xfer(fr(5'h16, 1'b1, 9'h002), 8, rsp);
        rd(5'h16, rs(5'h14, 10'h005));
        rb(3'h0, 10'h011);
        rb(3'h0, 10'h000);
        $display("error test done");
        wr(5'h1b, 9'h080);
        wr(5'h18, 9'h002);
        check({15'h0000, save_busy_o}, 16'h0000);
        save;
        wr(5'h16, 9'h003);
        check({13'h0000, speed_resolution_select_o}, 16'h0005);
        repeat (1000) if (save_busy_o) @(negedge ref_clk_i);
        rd(5'h18, rs(5'h14, 10'h001));
        reset_dut;
        rd(5'h16, rs(5'h18, 10'h005));
        rd(5'h1b, rs(5'h00, 10'h000));
        rb(3'h5, 10'h0c8);
        $display("save test done");
        save;
        vpp_low_i = 1'b1;
        repeat (1000) if (save_busy_o) @(negedge ref_clk_i);
        vpp_low_i = 1'b0;
        rd(5'h18, rs(5'h10, 10'h000));
        $display("abort test done");
        test_done;
    end
endmodule // rbn_top_test
`default_nettype wire
